// [rtl/sdic_pkg.sv]
package sdic_pkg;

   // Clock rate and idle time before standstill reduction
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned IDLE_TIME_MS    = 1500;
   // Longest time rounds down to whole cycles
   localparam int unsigned IDLE_CYCLES     = (CLK_HZ / 1000) * IDLE_TIME_MS;

   // Ring counter width and reset position
   localparam int unsigned RING_W          = 8;
   localparam logic [7:0]  RING_RST        = 8'h00;

   // Current levels driven to the regulator
   typedef enum logic [1:0] {
      SDIC_CUR_OFF  = 2'h0,
      SDIC_CUR_HALF = 2'h1,
      SDIC_CUR_FULL = 2'h2
   } sdic_cur_t;

   // Phase drive bundle
   typedef struct packed {
      logic [7:0] ring_pos;
      sdic_cur_t  level;
   } sdic_drive_t;

endpackage

// [rtl/sdic_step_dir_input_control.sv]
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Step on falling step edge only
// - Sense high or open: default direction
// - Sense low: opposite direction
// - Gate high: all phase currents off
// - Gate low: windings powered again
// - Ring counter advances while gated
// - Re-energise at reached ring position
// - Reduce current after idle pause
// - Restore full current at once
module sdic_step_dir_input_control
   import sdic_pkg::*;
#(
   parameter int unsigned IDLE_CNT = IDLE_CYCLES
) (
   input  wire logic        clock,       // 100 MHz system clock
   input  wire logic        resetn,      // Async reset, active low
   input  wire logic        step_n,      // Step pulse pin, active low
   input  wire logic        dir_n,       // Rotation sense pin, low = reverse
   input  wire logic        gate_n,      // Output gate pin, low = energised
   input  wire logic        reduce_n,    // Standstill reduction request, low = on
   output sdic_drive_t      drive,       // Ring position and current level
   output logic             step_pulse   // One-cycle pulse per accepted step
);

   // Synchronised pins, step edge history, ring position and idle timer
   logic [1:0]        step_s_r;
   logic [1:0]        dir_s_r;
   logic [1:0]        gate_s_r;
   logic [1:0]        red_s_r;
   logic              step_d_r;
   logic [RING_W-1:0] ring_r;
   logic [31:0]       idle_r;
   logic              idle_done_r;
   sdic_drive_t       drive_r;
   sdic_cur_t         level_nxt;

   // Two-stage synchronisers; pins are asynchronous to the clock
   // Reset to the idle pin levels so the release makes no false step edge
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         step_s_r <= 2'b11;
         dir_s_r  <= 2'b11;
         gate_s_r <= 2'b11;
         red_s_r  <= 2'b11;
      end else begin
         step_s_r <= {step_s_r[0], step_n};
         dir_s_r  <= {dir_s_r[0], dir_n};
         gate_s_r <= {gate_s_r[0], gate_n};
         red_s_r  <= {red_s_r[0], reduce_n};
      end
   end

   // Edge history taken from second stage only
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         step_d_r <= 1'b1;
      end else begin
         step_d_r <= step_s_r[1];
      end
   end

   assign step_pulse = step_d_r & ~step_s_r[1];

   // Ring counter runs regardless of gate, so phase stays in step with commands
   // Count while gated
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ring_r <= RING_RST;
      end else if (step_pulse) begin
         if (dir_s_r[1]) begin
            ring_r <= ring_r + RING_W'(1);
         end else begin
            ring_r <= ring_r - RING_W'(1);
         end
      end
   end

   // Idle timer; saturates so reduction holds through long standstill
   // Timer is 32 bits, enough for the longest pause at the full clock rate
   // Restart on step
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         idle_r      <= 32'h0000_0000;
         idle_done_r <= 1'b0;
      end else if (step_pulse) begin
         idle_r      <= 32'h0000_0000;
         idle_done_r <= 1'b0;
      end else if (idle_r >= 32'(IDLE_CNT - 1)) begin
         idle_done_r <= 1'b1;
      end else begin
         idle_r <= idle_r + 32'h0000_0001;
      end
   end

   // Current level select
   // Gate wins over reduction, so a gated motor never draws half current
   always_comb begin
      if (gate_s_r[1]) begin
         level_nxt = SDIC_CUR_OFF;
      end else if (!red_s_r[1] && idle_done_r) begin
         level_nxt = SDIC_CUR_HALF;
      end else begin
         level_nxt = SDIC_CUR_FULL;
      end
   end

   // Registered drive output
   // Position and level move together on one edge, never apart
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         drive_r <= '{ring_pos: RING_RST, level: SDIC_CUR_OFF};
      end else begin
         drive_r <= '{ring_pos: ring_r, level: level_nxt};
      end
   end

   // Drive bundle straight from its register
   assign drive = drive_r;

   step_edge_a: assert property (@(posedge clock) disable iff (!resetn)
      step_pulse |-> ##1 (ring_r != $past(ring_r)))
      else $error("ring did not move on step");

   ring_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      !step_pulse |=> $stable(ring_r))
      else $error("ring moved without step");

   pulse_once_a: assert property (@(posedge clock) disable iff (!resetn)
      step_pulse |=> !step_pulse)
      else $error("step pulse longer than one cycle");

   dir_fwd_a: assert property (@(posedge clock) disable iff (!resetn)
      (step_pulse && dir_s_r[1]) |=> ring_r == $past(ring_r) + RING_W'(1))
      else $error("forward step wrong");

   dir_rev_a: assert property (@(posedge clock) disable iff (!resetn)
      (step_pulse && !dir_s_r[1]) |=> ring_r == $past(ring_r) - RING_W'(1))
      else $error("reverse step wrong");

   gate_off_a: assert property (@(posedge clock) disable iff (!resetn)
      gate_s_r[1] |=> drive.level == SDIC_CUR_OFF)
      else $error("current on while gated");

   gate_on_a: assert property (@(posedge clock) disable iff (!resetn)
      (!gate_s_r[1] && red_s_r[1]) |=> drive.level == SDIC_CUR_FULL)
      else $error("no current after ungate");

   gated_count_a: assert property (@(posedge clock) disable iff (!resetn)
      (step_pulse && gate_s_r[1]) |=> ring_r != $past(ring_r))
      else $error("ring stalled while gated");

   resume_pos_a: assert property (@(posedge clock) disable iff (!resetn)
      ##1 drive.ring_pos == $past(ring_r))
      else $error("drive position stale");

   idle_reduce_a: assert property (@(posedge clock) disable iff (!resetn)
      (idle_done_r && !red_s_r[1] && !gate_s_r[1]) |=> drive.level == SDIC_CUR_HALF)
      else $error("no reduction after idle");

   half_cause_a: assert property (@(posedge clock) disable iff (!resetn)
      drive.level == SDIC_CUR_HALF |-> $past(idle_done_r) && !$past(red_s_r[1]) && !$past(gate_s_r[1]))
      else $error("half current without idle request");

   idle_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      (idle_done_r && !step_pulse) |=> idle_done_r)
      else $error("idle flag dropped without step");

   step_restore_a: assert property (@(posedge clock) disable iff (!resetn)
      step_pulse |=> !idle_done_r && idle_r == 32'h0000_0000)
      else $error("idle timer not restarted");

   fast_restore_a: assert property (@(posedge clock) disable iff (!resetn)
      (step_pulse && !gate_s_r[1]) ##1 !gate_s_r[1] |=> drive.level == SDIC_CUR_FULL)
      else $error("full current late");

   reduce_end_a: assert property (@(posedge clock) disable iff (!resetn)
      ($rose(red_s_r[1]) && !gate_s_r[1]) |=> drive.level == SDIC_CUR_FULL)
      else $error("full current late after reduction end");

   // Main scenarios
   cov_fwd: cover property (@(posedge clock) disable iff (!resetn) step_pulse && dir_s_r[1]);
   cov_rev: cover property (@(posedge clock) disable iff (!resetn) step_pulse && !dir_s_r[1]);
   cov_gated: cover property (@(posedge clock) disable iff (!resetn) step_pulse && gate_s_r[1]);
   cov_reduce: cover property (@(posedge clock) disable iff (!resetn) drive.level == SDIC_CUR_HALF);
   cov_resume: cover property (@(posedge clock) disable iff (!resetn) $fell(gate_s_r[1]));

endmodule

`default_nettype wire

// [tb/sdic_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Far-side motion controller, one step per request
module sdic_ctrl_model #(
   parameter int PW  = 201,   // Pulse width and pause, cycles
   parameter int DSU = 12001  // Sense setup before a step, cycles
) (
   input  wire logic clock,   // System clock
   input  wire logic go,      // Step request
   input  wire logic dir_req, // Wanted sense level
   output logic      step_n,  // Step pin
   output logic      dir_n,   // Sense pin
   output logic      busy     // Step under way
);
   // Pins move on falling edges; go and busy meet on rising edges, so no race with the bench
   initial begin
      step_n = 1'b1;
      dir_n  = 1'b1;
      busy   = 1'b0;
      forever begin
         @(posedge clock);
         if (go) begin
            busy = 1'b1;
            @(negedge clock);
            if (dir_n !== dir_req) begin
               dir_n = dir_req;
               repeat (DSU) @(negedge clock);
            end
            step_n = 1'b0;
            repeat (PW) @(negedge clock);
            step_n = 1'b1;
            repeat (PW) @(negedge clock);
            @(posedge clock);
            busy = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/sdic_step_dir_input_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module sdic_step_dir_input_control_tb
   import sdic_pkg::*;
;
   logic        clock, resetn, gate_n, reduce_n, go, dir_req, step_n, dir_n, busy, step_pulse, seen_full;
   sdic_drive_t drive;
   int          fail_count = 0;
   int          total_checks = 0;
   int          pulses = 0;

   sdic_step_dir_input_control #(.IDLE_CNT(50)) u_sdic_step_dir_input_control (.clock(clock), .resetn(resetn),
      .step_n(step_n), .dir_n(dir_n), .gate_n(gate_n), .reduce_n(reduce_n), .drive(drive), .step_pulse(step_pulse));
   sdic_ctrl_model u_sdic_ctrl_model (.clock(clock), .go(go), .dir_req(dir_req), .step_n(step_n), .dir_n(dir_n),
      .busy(busy));

   // Clock, 10 ns period
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Count accepted steps
   always @(posedge clock) if (step_pulse === 1'b1) pulses++;

   task automatic end_sim;
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One step through the model; bounded waits on its busy flag
   task automatic run_step(input logic d);
      int i;
      dir_req = d;
      go = 1'b1;
      for (i = 0; i < 20000 && busy !== 1'b1; i++) @(negedge clock);
      go = 1'b0;
      if (busy !== 1'b1) begin
         fail_count++;
         end_sim();
      end
      for (i = 0; i < 20000 && busy !== 1'b0; i++) begin
         @(negedge clock);
         if (drive.level === SDIC_CUR_FULL) seen_full = 1'b1;
      end
      if (busy !== 1'b0) begin
         fail_count++;
         end_sim();
      end
   endtask

   task automatic check_steps;
      repeat (3) run_step(1'b1);
      `CHK("ring", 8'h03, drive.ring_pos)
      `CHK("pulses", 3, pulses)
      repeat (5) run_step(1'b0);
      `CHK("ring", 8'hFE, drive.ring_pos)
   endtask

   task automatic check_gate;
      gate_n = 1'b1;
      repeat (5) @(negedge clock);
      `CHK("level", SDIC_CUR_OFF, drive.level)
      repeat (2) run_step(1'b0);
      `CHK("ring", 8'hFC, drive.ring_pos)
      gate_n = 1'b0;
      repeat (5) @(negedge clock);
      `CHK("level", SDIC_CUR_FULL, drive.level)
      `CHK("ring", 8'hFC, drive.ring_pos)
   endtask

   task automatic check_idle;
      reduce_n = 1'b0;
      repeat (60) @(negedge clock);
      `CHK("level", SDIC_CUR_HALF, drive.level)
      seen_full = 1'b0;
      run_step(1'b0);
      `CHK("seen_full", 1'b1, seen_full)
      `CHK("level", SDIC_CUR_HALF, drive.level)
      gate_n = 1'b1;
      repeat (4) @(negedge clock);
      `CHK("level", SDIC_CUR_OFF, drive.level)
      gate_n = 1'b0;
      repeat (4) @(negedge clock);
      `CHK("level", SDIC_CUR_HALF, drive.level)
      reduce_n = 1'b1;
      repeat (3) @(negedge clock);
      `CHK("level", SDIC_CUR_FULL, drive.level)
   endtask

   // Reset for three cycles, then the scenarios
   initial begin
      resetn = 1'b0;
      gate_n = 1'b0;
      reduce_n = 1'b1;
      go = 1'b0;
      dir_req = 1'b1;
      seen_full = 1'b0;
      repeat (3) @(negedge clock);
      resetn = 1'b1;
      repeat (3) @(negedge clock);
      check_steps();
      check_gate();
      check_idle();
      end_sim();
   end
endmodule
`default_nettype wire
